// ===== inc/hfs_defs.vh
// Constants for the frame status queue block.
// Assumes byte-wide register values carried in the low bits of a 32-bit bus.
`ifndef HFS_DEFS_VH
`define HFS_DEFS_VH
`define HFS_DEPTH 10
`define HFS_PTR_W 4
`define HFS_LAST_PTR 4'h9
`define HFS_ENTRY_W 19
`define HFS_CNT_W 14
`define HFS_STAT_W 5
// Entry layout: residue, overrun, CRC error, then the byte count
`define HFS_E_RES_HI 18
`define HFS_E_RES_LO 16
`define HFS_E_OVR 15
`define HFS_E_CRC 14
`define HFS_E_CHI_HI 13
`define HFS_E_CHI_LO 8
`define HFS_E_CLO_HI 7
`define HFS_E_CLO_LO 0
// Register byte addresses (index times four)
`define HFS_A_BUF_EXT 8'h00
`define HFS_A_RX_COND 8'h04
`define HFS_A_REG2 8'h08
`define HFS_A_REG3 8'h0c
`define HFS_A_ALIAS4 8'h10
`define HFS_A_ALIAS5 8'h14
`define HFS_A_CNT_LO 8'h18
`define HFS_A_CNT_HI 8'h1c
`define HFS_A_QCTRL 8'h3c
`define HFS_A_EXT_INFO 8'h3c
`define HFS_A_MODE 8'h40
`define HFS_A_LIVE 8'h44
// Field positions
`define HFS_QEN_BIT 2
`define HFS_AVAIL_BIT 6
`define HFS_OVF_BIT 7
`define HFS_CRC_BIT 6
`define HFS_OVR_BIT 5
`define HFS_EOF_BIT 7
`define HFS_QCTRL_RST 8'h00
`define HFS_RESP_OK 2'h0
`define HFS_RESP_ERR 2'h2
`endif

// ===== rtl/hfs_byte_counter.v
// Fourteen-bit receive byte counter.
// Assumes flag and byte-write strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.vh"
module hfs_byte_counter (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Control
  input wire i_enable,
  input wire i_flag,
  input wire i_byte_wr,
  // Count
  output wire [`HFS_CNT_W-1:0] o_count
);
  reg [`HFS_CNT_W-1:0] cnt_reg;
  assign o_count = cnt_reg;
  always @(posedge i_clock)
  begin
    if (i_srst)
      cnt_reg <= {`HFS_CNT_W{1'b0}};
    else if (!i_enable)
      cnt_reg <= {`HFS_CNT_W{1'b0}};
    else if (i_flag)
      cnt_reg <= {`HFS_CNT_W{1'b0}};
    else if (i_byte_wr)
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule
`default_nettype wire

// ===== rtl/hfs_frame_status.v
// Frame status queue, byte counter and status registers over AXI4-Lite.
// Assumes receiver events arrive as one-cycle pulses on i_clock.
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.vh"
module hfs_frame_status (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  input wire i_chan_rst,
  // AXI4-Lite write address and data
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  // AXI4-Lite write response
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  // AXI4-Lite read
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Receiver events
  input wire i_flag,
  input wire i_eof,
  input wire i_byte_wr,
  // Live receive status
  input wire [2:0] i_residue,
  input wire i_overrun,
  input wire i_crc_err,
  input wire i_all_sent,
  input wire i_parity_err,
  // Legacy register contents
  input wire [7:0] i_buf_ext_status,
  input wire [7:0] i_reg2,
  input wire [7:0] i_reg3,
  input wire [7:0] i_ext_info,
  // Receiver control
  output reg o_crc_reset
);
  reg [7:0] qctrl_reg;
  reg bitsync_reg;
  reg aw_held_reg;
  reg [7:0] aw_addr_reg;
  reg w_held_reg;
  reg [7:0] w_data_reg;
  reg w_lane_reg;
  reg live_sel_reg;
  reg [7:0] rd_byte;
  reg pop;
  reg rd_err;
  wire q_on;
  wire q_clear;
  wire q_empty;
  wire q_ovf;
  wire [`HFS_ENTRY_W-1:0] q_head;
  wire [`HFS_ENTRY_W-1:0] q_entry;
  wire [`HFS_CNT_W-1:0] byte_count;
  wire use_head;
  wire wr_go;
  wire ar_go;
  wire [7:0] live_cond;
  wire [7:0] queued_cond;
  // Head entry fields, named so the read mux stays readable
  wire [2:0] head_res;
  wire head_ovr;
  wire head_crc;
  wire [7:0] head_cnt_lo;
  wire [5:0] head_cnt_hi;
  function [7:0] cond_byte;
    input [2:0] res;
    input ovr;
    input crc;
    input sent;
    input par;
    input eof;
    begin
      cond_byte = {eof, crc, ovr, par, res, sent};
    end
  endfunction
  assign q_on = qctrl_reg[`HFS_QEN_BIT] && bitsync_reg;
  assign q_clear = i_srst || i_chan_rst || !q_on;
  assign q_entry = {i_residue, i_overrun, i_crc_err, byte_count};
  assign use_head = q_on && !q_empty && !live_sel_reg;
  assign live_cond = cond_byte(i_residue, i_overrun, i_crc_err,
    i_all_sent, i_parity_err, i_eof);
  assign head_res = q_head[`HFS_E_RES_HI:`HFS_E_RES_LO];
  assign head_ovr = q_head[`HFS_E_OVR];
  assign head_crc = q_head[`HFS_E_CRC];
  assign head_cnt_lo = q_head[`HFS_E_CLO_HI:`HFS_E_CLO_LO];
  assign head_cnt_hi = q_head[`HFS_E_CHI_HI:`HFS_E_CHI_LO];
  // All sent, parity and end of frame always come live, never queued
  assign queued_cond = cond_byte(head_res, head_ovr, head_crc,
    i_all_sent, i_parity_err, i_eof);
  hfs_status_queue u_queue (
    .i_clock(i_clock),
    .i_clear(q_clear),
    .i_push(i_eof && q_on),
    .i_entry(q_entry),
    .i_pop(pop),
    .o_head(q_head),
    .o_empty(q_empty),
    .o_overflow(q_ovf)
  );
  hfs_byte_counter u_count (
    .i_clock(i_clock),
    .i_srst(i_srst || i_chan_rst),
    .i_enable(bitsync_reg),
    .i_flag(i_flag),
    .i_byte_wr(i_byte_wr),
    .o_count(byte_count)
  );
  assign wr_go = aw_held_reg && w_held_reg && !o_bvalid;
  assign ar_go = i_arvalid && o_arready;
  // Read decode; pop only on the status register with the queue in use
  always @*
  begin
    rd_byte = 8'h00;
    pop = 1'b0;
    rd_err = 1'b0;
    case (i_araddr)
      `HFS_A_BUF_EXT, `HFS_A_ALIAS4:
        rd_byte = (i_araddr == `HFS_A_ALIAS4 && q_on) ? 8'h00 :
          i_buf_ext_status;
      `HFS_A_RX_COND, `HFS_A_ALIAS5:
      begin
        if (i_araddr == `HFS_A_ALIAS5 && q_on)
          rd_byte = 8'h00;
        else if (use_head)
        begin
          rd_byte = queued_cond;
          pop = ar_go && (i_araddr == `HFS_A_RX_COND);
        end
        else
          rd_byte = live_cond;
      end
      `HFS_A_REG2:
        rd_byte = i_reg2;
      `HFS_A_CNT_LO:
        rd_byte = q_on ? (use_head ? head_cnt_lo : 8'h00) : i_reg2;
      `HFS_A_REG3:
        rd_byte = i_reg3;
      `HFS_A_CNT_HI:
        rd_byte = q_on ? {q_ovf, !q_empty, head_cnt_hi} : i_reg3;
      `HFS_A_EXT_INFO:
      begin
        rd_byte = i_ext_info;
        rd_byte[`HFS_QEN_BIT] = q_on;
      end
      `HFS_A_MODE:
        rd_byte = {7'h00, bitsync_reg};
      default:
        rd_err = 1'b1;
    endcase
  end
  // Write channels are taken independently and held until both arrive
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `HFS_RESP_OK;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      qctrl_reg <= `HFS_QCTRL_RST;
      bitsync_reg <= 1'b0;
    end
    else
    begin
      o_awready <= !aw_held_reg && !(i_awvalid && o_awready);
      o_wready <= !w_held_reg && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_wdata[7:0];
        w_lane_reg <= i_wstrb[0];
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= `HFS_RESP_OK;
        if (aw_addr_reg == `HFS_A_QCTRL)
        begin
          if (w_lane_reg)
            qctrl_reg <= w_data_reg;
        end
        else if (aw_addr_reg == `HFS_A_MODE)
        begin
          if (w_lane_reg)
            bitsync_reg <= w_data_reg[0];
        end
        else
          o_bresp <= `HFS_RESP_ERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end
  // Read channel, plus the empty latch set by the high count read
  always @(posedge i_clock)
  begin
    if (i_srst || i_chan_rst)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `HFS_RESP_OK;
      live_sel_reg <= 1'b0;
    end
    else
    begin
      o_arready <= !o_rvalid && !ar_go;
      if (ar_go)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= {24'h000000, rd_byte};
        o_rresp <= rd_err ? `HFS_RESP_ERR : `HFS_RESP_OK;
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
      if (ar_go && i_araddr == `HFS_A_CNT_HI && q_on)
        live_sel_reg <= q_empty;
      // A frame end that fills the queue again releases the live steering
      else if (!q_on || (i_eof && q_empty))
        live_sel_reg <= 1'b0;
    end
  end
  always @(posedge i_clock)
  begin
    if (i_srst || i_chan_rst)
      o_crc_reset <= 1'b0;
    else
      o_crc_reset <= i_eof;
  end
endmodule
`default_nettype wire

// ===== rtl/hfs_status_queue.v
// Ten-entry frame status queue with overflow flag.
// Assumes i_clear is asserted for reset and whenever the queue is off.
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.vh"
module hfs_status_queue (
  // Clock and clear
  input wire i_clock,
  input wire i_clear,
  // Write side
  input wire i_push,
  input wire [`HFS_ENTRY_W-1:0] i_entry,
  // Read side
  input wire i_pop,
  output wire [`HFS_ENTRY_W-1:0] o_head,
  output wire o_empty,
  output wire o_overflow
);
  reg [`HFS_ENTRY_W-1:0] mem [0:`HFS_DEPTH-1];
  reg [`HFS_PTR_W-1:0] wr_reg;
  reg [`HFS_PTR_W-1:0] rd_reg;
  reg [`HFS_PTR_W:0] cnt_reg;
  reg ovf_reg;
  wire full;
  wire do_push;
  wire do_pop;
  function [`HFS_PTR_W-1:0] bump;
    input [`HFS_PTR_W-1:0] p;
    begin
      bump = (p == `HFS_LAST_PTR) ? {`HFS_PTR_W{1'b0}} : p + 1'b1;
    end
  endfunction
  assign full = (cnt_reg == `HFS_DEPTH);
  assign o_empty = (cnt_reg == 0);
  assign do_push = i_push && !full;
  assign do_pop = i_pop && !o_empty;
  assign o_head = mem[rd_reg];
  assign o_overflow = ovf_reg;
  always @(posedge i_clock)
  begin
    if (do_push)
      mem[wr_reg] <= i_entry;
  end
  always @(posedge i_clock)
  begin
    if (i_clear)
    begin
      wr_reg <= {`HFS_PTR_W{1'b0}};
      rd_reg <= {`HFS_PTR_W{1'b0}};
      cnt_reg <= {(`HFS_PTR_W+1){1'b0}};
      ovf_reg <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_reg <= bump(wr_reg);
      if (do_pop)
        rd_reg <= bump(rd_reg);
      if (do_push && !do_pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_pop && !do_push)
        cnt_reg <= cnt_reg - 1'b1;
      if (i_push && full && !do_pop)
        ovf_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/hdlc_frame_status_fifo_tb_top.sv
// Self-checking bench for the frame status block.
// Assumes the event source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module hdlc_frame_status_fifo_tb_top;
  logic i_clock = 1'h0;
  logic i_srst = 1'h1;
  logic i_chan_rst = 1'h0;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic i_arvalid = 1'h0, i_rready = 1'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_crc_reset;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire i_flag, i_eof, i_byte_wr;
  logic [2:0] i_residue = 3'h5;
  logic i_overrun = 1'h0, i_crc_err = 1'h1;
  logic i_all_sent = 1'h1, i_parity_err = 1'h0;
  logic [7:0] i_buf_ext_status = 8'h5a, i_reg2 = 8'h33, i_reg3 = 8'h44;
  logic [7:0] i_ext_info = 8'h80;
  int err_count = 0;
  int check_count = 0;
  int n;
  logic [31:0] d;
  logic [1:0] rr;
  logic [1:0] br;
  // Response code, address, expected byte
  logic [17:0] rows [11] = '{18'h0005a, 18'h0044b, 18'h00833, 18'h00c44,
    18'h0105a, 18'h0144b, 18'h01833, 18'h01c44, 18'h03c80, 18'h04000,
    18'h28000};
  hfs_frame_status i_dut (.*);
  hfs_frame_src i_src (.i_clock(i_clock), .o_byte_wr(i_byte_wr),
    .o_eof(i_eof), .o_flag(i_flag));
  always #50 i_clock = ~i_clock;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge i_clock);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do
      begin
        @(posedge i_clock);
        if (o_awready)
          i_awvalid <= 1'h0;
        if (o_wready)
          i_wvalid <= 1'h0;
      end while (!o_bvalid);
      br = o_bresp;
      i_bready <= 1'h0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    begin
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do
      begin
        @(posedge i_clock);
        if (o_arready)
          i_arvalid <= 1'h0;
      end while (!o_rvalid);
      v = o_rdata;
      rr = o_rresp;
      i_rready <= 1'h0;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    begin
      rd(a, d);
      `CHK({rr, d}, {2'h0, 24'h0, e})
    end
  endtask
  task automatic end_sim();
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    #3000000;
    err_count++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_srst <= 1'h0;
    for (n = 0; n < 11; n++)
    begin
      rd(rows[n][15:8], d);
      `CHK({rr, d}, {rows[n][17:16], 24'h0, rows[n][7:0]})
    end
    $display("done: legacy map");
    wr(8'h40, 32'h1);
    `CHK(br, 2'h0)
    wr(8'h3c, 32'h4);
    `CHK(br, 2'h0)
    wr(8'h80, 32'h0);
    `CHK(br, 2'h2)
    rc(8'h3c, 8'h84);
    rc(8'h10, 8'h00);
    i_src.frame(3);
    i_crc_err <= 1'h0;
    i_overrun <= 1'h1;
    i_src.frame(2);
    // Live status now differs from both stored entries
    i_crc_err <= 1'h1;
    i_parity_err <= 1'h1;
    rc(8'h1c, 8'h40);
    rc(8'h18, 8'h03);
    rc(8'h04, 8'h5b);
    rc(8'h18, 8'h02);
    rc(8'h18, 8'h02);
    rc(8'h04, 8'h3b);
    rd(8'h1c, d);
    `CHK(d[7:6], 2'h0)
    rc(8'h04, 8'h7b);
    rc(8'h04, 8'h7b);
    i_src.frame(1);
    rc(8'h1c, 8'h40);
    rc(8'h18, 8'h01);
    rc(8'h04, 8'h7b);
    $display("done: queue order");
    for (n = 1; n < 12; n++)
      i_src.frame(n);
    rc(8'h1c, 8'hc0);
    rc(8'h18, 8'h01);
    wr(8'h3c, 32'h0);
    wr(8'h3c, 32'h4);
    rd(8'h1c, d);
    `CHK(d[7:6], 2'h0)
    $display("done: overflow");
    wr(8'h40, 32'h0);
    i_src.frame(2);
    rc(8'h1c, 8'h44);
    wr(8'h40, 32'h1);
    rd(8'h1c, d);
    `CHK(d[6], 1'h0)
    i_src.frame(2);
    @(posedge i_clock);
    i_chan_rst <= 1'h1;
    @(posedge i_clock);
    i_chan_rst <= 1'h0;
    rd(8'h1c, d);
    `CHK(d[6], 1'h0)
    // Full reset in mid-run must drop the enable and the mode again
    @(posedge i_clock);
    i_srst <= 1'h1;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'h0;
    rc(8'h3c, 8'h80);
    rc(8'h40, 8'h00);
    rc(8'h1c, 8'h44);
    $display("done: mode and reset");
    end_sim();
  end
endmodule
`default_nettype wire

// ===== testbench/hfs_chk_monitor.sv
// Port checker for the frame status block.
// Assumes it is bound onto the top module.
`timescale 1ns/1ps
`default_nettype none
module hfs_chk (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Register bus
  input wire i_awvalid,
  input wire o_awready,
  input wire i_wvalid,
  input wire o_wready,
  input wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0] o_rresp,
  input wire o_rvalid,
  input wire i_rready,
  // Receiver
  input wire i_eof,
  input wire o_crc_reset
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  property p_crc;
    i_eof |=> o_crc_reset;
  endproperty
  a_crc: assert property (p_crc) else $error("no crc reset");
  property p_crc1;
    !$past(i_eof) |-> !o_crc_reset;
  endproperty
  a_crc1: assert property (p_crc1) else $error("stray crc reset");
  property p_ar;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_rh;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_unm;
    i_arvalid && o_arready && i_araddr == 8'h80 |=>
      o_rresp == 2'h2 && o_rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read accepted");
  property p_bh;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_ro;
    o_rvalid |-> !o_arready;
  endproperty
  a_ro: assert property (p_ro) else $error("second read taken");
  property p_wr;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
endmodule
bind hfs_frame_status hfs_chk u_chk (.*);
`default_nettype wire

// ===== testbench/hfs_frame_src.sv
// Receiver event source standing in for the serial receiver.
// Assumes the caller starts a frame just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module hfs_frame_src (
  // Clock
  input wire logic i_clock,
  // Receiver events
  output var logic o_byte_wr,
  output var logic o_eof,
  output var logic o_flag
);
  initial
  begin
    o_byte_wr = 1'h0;
    o_eof = 1'h0;
    o_flag = 1'h0;
  end
  // Closing flag shares the frame end cycle, the hardest case for capture
  task automatic frame(input int n);
    int k;
    begin
      for (k = 0; k < n; k++)
      begin
        @(posedge i_clock);
        o_byte_wr <= 1'h1;
        @(posedge i_clock);
        o_byte_wr <= 1'h0;
      end
      @(posedge i_clock);
      o_eof <= 1'h1;
      o_flag <= 1'h1;
      @(posedge i_clock);
      o_eof <= 1'h0;
      o_flag <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire
